// file: fesl_ctrl.sv
`timescale 1ns/10ps
module fesl_ctrl #(
    parameter logic [19:0] ERASE_CYCLES = fesl_pkg::ERASE_CYC
) (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        ce_n_i,
    input  wire logic                        we_i,
    input  wire logic [fesl_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [fesl_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                        wp_n_i,
    input  wire logic                        vpp_lockout_i,
    input  wire logic                        erase_fail_i,
    input  wire logic [fesl_pkg::DATA_W-1:0] array_rdata_i,
    output logic      [fesl_pkg::DATA_W-1:0] rdata_o,
    output logic      [7:0]                  status_o,
    output logic                             standby_o,
    output logic                             array_erase_o,
    output logic                             array_prog_o,
    output logic      [fesl_pkg::ADDR_W-1:0] array_addr_o,
    output logic      [fesl_pkg::DATA_W-1:0] array_data_o,
    output logic      [fesl_pkg::DATA_W-1:0] rcr_o
);
    localparam int unsigned BW = fesl_pkg::BLK_W;

    fesl_pkg::fesl_rmode_t        rmode_q, rmode_d;
    fesl_pkg::fesl_seq_t          seq_q, seq_d;
    fesl_pkg::fesl_op_t           eop_q, eop_d, pop_q, pop_d;
    logic [fesl_pkg::CNT_W-1:0]   ecnt_q, ecnt_d, pcnt_q, pcnt_d;
    logic [BW-1:0]                eblk_q, eblk_d;
    logic [fesl_pkg::NBLK-1:0]    lock_q, lock_d, ldn_q, ldn_d;
    logic [7:0]                   err_q, err_set, err_clr;
    logic [fesl_pkg::DATA_W-1:0]  rcr_q, rcr_d, rdata_d;
    logic [fesl_pkg::ADDR_W-1:0]  paddr_q, paddr_d;
    logic [fesl_pkg::DATA_W-1:0]  pdata_q, pdata_d;
    logic                         standby_d, erase_p_d, prog_p_d, erase_p_q, prog_p_q;
    logic [7:0]                   sr;
    logic [7:0]                   cmd;
    logic [BW-1:0]                blk;
    logic                         wr, busy;

    // Commands valid while suspended; anything else is dropped silently
    function automatic logic cmd_ok(input logic [7:0] c, input logic esusp, input logic psusp);
        logic rd;
        rd = (c == fesl_pkg::CMD_READ_ARRAY) || (c == fesl_pkg::CMD_READ_STATUS) ||
             (c == fesl_pkg::CMD_READ_ID) || (c == fesl_pkg::CMD_QUERY) || (c == fesl_pkg::CMD_CONFIRM);
        if (psusp) begin
            cmd_ok = rd;
        end else if (esusp) begin
            cmd_ok = rd || (c == fesl_pkg::CMD_CLEAR) || (c == fesl_pkg::CMD_PROG) ||
                     (c == fesl_pkg::CMD_PROG_ALT) || (c == fesl_pkg::CMD_SUSPEND) ||
                     (c == fesl_pkg::CMD_LOCK_SETUP);
        end else begin
            cmd_ok = 1'b1;
        end
    endfunction

    assign cmd  = wdata_i[7:0];
    assign blk  = addr_i[fesl_pkg::ADDR_W-1 -: BW];
    assign wr   = we_i && !ce_n_i;
    assign busy = (eop_q == fesl_pkg::OP_RUN) || (pop_q == fesl_pkg::OP_RUN);

    // Live status view; bit 0 follows the block now being addressed
    always_comb begin
        sr                      = err_q;
        sr[fesl_pkg::SR_READY]  = !busy;
        sr[fesl_pkg::SR_ESUSP]  = (eop_q == fesl_pkg::OP_SUSP);
        sr[fesl_pkg::SR_PSUSP]  = (pop_q == fesl_pkg::OP_SUSP);
        sr[fesl_pkg::SR_BLK_ERS] = (eop_q == fesl_pkg::OP_RUN) && (blk == eblk_q);
    end

    // Write state machine, command decoder and lock state
    always_comb begin
        rmode_d   = rmode_q;
        seq_d     = seq_q;
        eop_d     = eop_q;
        pop_d     = pop_q;
        ecnt_d    = ecnt_q;
        pcnt_d    = pcnt_q;
        eblk_d    = eblk_q;
        lock_d    = lock_q;
        ldn_d     = ldn_q;
        rcr_d     = rcr_q;
        paddr_d   = paddr_q;
        pdata_d   = pdata_q;
        err_set   = 8'h00;
        err_clr   = 8'h00;
        erase_p_d = 1'b0;
        prog_p_d  = 1'b0;
        // Erase timer keeps running even while deselected
        if (eop_q == fesl_pkg::OP_RUN) begin
            if (vpp_lockout_i) begin
                eop_d = fesl_pkg::OP_NONE;
                err_set[fesl_pkg::SR_VPP] = 1'b1;
            end else if (ecnt_q == 20'h0_0001) begin
                eop_d = fesl_pkg::OP_NONE;
                erase_p_d = 1'b1;
                err_set[fesl_pkg::SR_ERASE] = erase_fail_i;
            end else begin
                ecnt_d = ecnt_q - 1'b1;
            end
        end
        if (pop_q == fesl_pkg::OP_RUN) begin
            if (vpp_lockout_i) begin
                pop_d = fesl_pkg::OP_NONE;
                err_set[fesl_pkg::SR_VPP] = 1'b1;
            end else if (pcnt_q == 20'h0_0001) begin
                pop_d = fesl_pkg::OP_NONE;
                prog_p_d = 1'b1;
            end else begin
                pcnt_d = pcnt_q - 1'b1;
            end
        end
        if (wr) begin
            case (seq_q)
                fesl_pkg::SQ_PROG: begin
                    seq_d   = fesl_pkg::SQ_NONE;
                    rmode_d = fesl_pkg::RM_STATUS;
                    if (eop_q == fesl_pkg::OP_SUSP && blk == eblk_q) begin
                        err_set[fesl_pkg::SR_PROG] = 1'b1;
                    end else if (lock_q[blk]) begin
                        err_set[fesl_pkg::SR_PROG] = 1'b1;
                        err_set[fesl_pkg::SR_LOCK] = 1'b1;
                    end else if (vpp_lockout_i) begin
                        err_set[fesl_pkg::SR_VPP] = 1'b1;
                    end else begin
                        pop_d   = fesl_pkg::OP_RUN;
                        pcnt_d  = fesl_pkg::PROG_CYC;
                        paddr_d = addr_i;
                        pdata_d = wdata_i;
                    end
                end
                fesl_pkg::SQ_ERASE: begin
                    seq_d   = fesl_pkg::SQ_NONE;
                    rmode_d = fesl_pkg::RM_STATUS;
                    if (cmd != fesl_pkg::CMD_CONFIRM) begin
                        err_set[fesl_pkg::SR_ERASE] = 1'b1;
                        err_set[fesl_pkg::SR_PROG]  = 1'b1;
                    end else if (lock_q[blk]) begin
                        err_set[fesl_pkg::SR_LOCK] = 1'b1;
                    end else if (vpp_lockout_i) begin
                        err_set[fesl_pkg::SR_VPP] = 1'b1;
                    end else begin
                        eop_d  = fesl_pkg::OP_RUN;
                        ecnt_d = ERASE_CYCLES;
                        eblk_d = blk;
                    end
                end
                fesl_pkg::SQ_LOCK: begin
                    // Lock bits ignore the program supply entirely
                    seq_d = fesl_pkg::SQ_NONE;
                    if (cmd == fesl_pkg::CMD_LOCK) begin
                        lock_d[blk] = 1'b1;
                    end else if (cmd == fesl_pkg::CMD_CONFIRM) begin
                        if (!ldn_q[blk] || wp_n_i) begin
                            lock_d[blk] = 1'b0;
                        end
                    end else if (cmd == fesl_pkg::CMD_LOCK_DOWN) begin
                        lock_d[blk] = 1'b1;
                        ldn_d[blk]  = 1'b1;
                    end else if (cmd == fesl_pkg::CMD_SET_RCR) begin
                        rcr_d = fesl_pkg::DATA_W'(addr_i);
                    end else begin
                        err_set[fesl_pkg::SR_ERASE] = 1'b1;
                        err_set[fesl_pkg::SR_PROG]  = 1'b1;
                    end
                end
                default: begin
                    if (busy) begin
                        // Busy: only suspend and status read are heard
                        if (cmd == fesl_pkg::CMD_SUSPEND) begin
                            rmode_d = fesl_pkg::RM_STATUS;
                            // Timer freezes at once; a suspend on the last cycle loses to completion
                            if (pop_d == fesl_pkg::OP_RUN) begin
                                pop_d  = fesl_pkg::OP_SUSP;
                                pcnt_d = pcnt_q;
                            end else if (eop_d == fesl_pkg::OP_RUN) begin
                                eop_d  = fesl_pkg::OP_SUSP;
                                ecnt_d = ecnt_q;
                            end
                        end else if (cmd == fesl_pkg::CMD_READ_STATUS) begin
                            rmode_d = fesl_pkg::RM_STATUS;
                        end
                    end else if (cmd_ok(cmd, eop_q == fesl_pkg::OP_SUSP, pop_q == fesl_pkg::OP_SUSP)) begin
                        case (cmd)
                            fesl_pkg::CMD_READ_ARRAY:  rmode_d = fesl_pkg::RM_ARRAY;
                            fesl_pkg::CMD_READ_STATUS: rmode_d = fesl_pkg::RM_STATUS;
                            fesl_pkg::CMD_READ_ID:     rmode_d = fesl_pkg::RM_ID;
                            fesl_pkg::CMD_QUERY:       rmode_d = fesl_pkg::RM_QUERY;
                            fesl_pkg::CMD_CLEAR: begin
                                err_clr = 8'h3A;
                            end
                            fesl_pkg::CMD_PROG, fesl_pkg::CMD_PROG_ALT: begin
                                seq_d = fesl_pkg::SQ_PROG;
                            end
                            fesl_pkg::CMD_ERASE_SETUP: begin
                                if (eop_q == fesl_pkg::OP_NONE) begin
                                    seq_d = fesl_pkg::SQ_ERASE;
                                end
                            end
                            fesl_pkg::CMD_LOCK_SETUP: begin
                                seq_d = fesl_pkg::SQ_LOCK;
                            end
                            fesl_pkg::CMD_CONFIRM: begin
                                // A program started in suspend resumes first
                                if (pop_q == fesl_pkg::OP_SUSP) begin
                                    pop_d   = fesl_pkg::OP_RUN;
                                    rmode_d = fesl_pkg::RM_STATUS;
                                end else if (eop_q == fesl_pkg::OP_SUSP) begin
                                    eop_d   = fesl_pkg::OP_RUN;
                                    rmode_d = fesl_pkg::RM_STATUS;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // Read data and standby are registered so the pins never glitch
    always_comb begin
        case (rmode_q)
            fesl_pkg::RM_STATUS: rdata_d = {8'h00, sr};
            fesl_pkg::RM_ID:     rdata_d = {14'h0000, ldn_q[blk], lock_q[blk]};
            fesl_pkg::RM_ARRAY:  rdata_d = array_rdata_i;
            default:             rdata_d = 16'h0000;
        endcase
        standby_d = ce_n_i && !busy;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Every block relocks and lock-down clears on reset
            rmode_q   <= fesl_pkg::RM_ARRAY;
            seq_q     <= fesl_pkg::SQ_NONE;
            eop_q     <= fesl_pkg::OP_NONE;
            pop_q     <= fesl_pkg::OP_NONE;
            ecnt_q    <= '0;
            pcnt_q    <= '0;
            eblk_q    <= '0;
            lock_q    <= fesl_pkg::LOCK_RST;
            ldn_q     <= fesl_pkg::LDN_RST;
            err_q     <= fesl_pkg::ERR_RST;
            rcr_q     <= fesl_pkg::RCR_RST;
            paddr_q   <= '0;
            pdata_q   <= '0;
            rdata_o   <= '0;
            standby_o <= 1'b0;
            erase_p_q <= 1'b0;
            prog_p_q  <= 1'b0;
        end else begin
            rmode_q   <= rmode_d;
            seq_q     <= seq_d;
            eop_q     <= eop_d;
            pop_q     <= pop_d;
            ecnt_q    <= ecnt_d;
            pcnt_q    <= pcnt_d;
            eblk_q    <= eblk_d;
            lock_q    <= lock_d;
            ldn_q     <= ldn_d;
            err_q     <= (err_q & ~err_clr) | err_set;               // Set beats clear
            rcr_q     <= rcr_d;
            paddr_q   <= paddr_d;
            pdata_q   <= pdata_d;
            rdata_o   <= rdata_d;
            standby_o <= standby_d;
            erase_p_q <= erase_p_d;
            prog_p_q  <= prog_p_d;
        end
    end

    assign status_o      = sr;
    assign rcr_o         = rcr_q;
    assign array_erase_o = erase_p_q;
    assign array_prog_o  = prog_p_q;
    // Host address reaches the array between pulses so read-array sees the right word
    assign array_addr_o  = erase_p_q ? {eblk_q, 8'h00} : (prog_p_q ? paddr_q : addr_i);
    assign array_data_o  = pdata_q;

    // Checks
    sequence s_erase_go;
        wr && seq_q == fesl_pkg::SQ_ERASE && cmd == fesl_pkg::CMD_CONFIRM;
    endsequence
    sequence s_erase_end;
        eop_q == fesl_pkg::OP_RUN && ecnt_q == 20'h0_0001 && !vpp_lockout_i;
    endsequence

    erase_locked_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_erase_go and lock_q[blk] |=> err_q[fesl_pkg::SR_LOCK] && eop_q == fesl_pkg::OP_NONE)
        else $error("locked erase not refused");
    erase_finish_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_erase_end |=> array_erase_o && status_o[fesl_pkg::SR_READY] ##1 !array_erase_o)
        else $error("erase completion wrong");
    erase_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_erase_go and !lock_q[blk] and !vpp_lockout_i |=> rmode_q == fesl_pkg::RM_STATUS
        ##1 rdata_o[fesl_pkg::SR_READY] == 1'b0)
        else $error("erase start not reporting status");
    prog_vpp_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pop_q == fesl_pkg::OP_RUN && vpp_lockout_i |=> err_q[fesl_pkg::SR_VPP] && pop_q != fesl_pkg::OP_RUN)
        else $error("supply lockout did not halt program");
    prog_resume_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && seq_q == fesl_pkg::SQ_NONE && !busy && pop_q == fesl_pkg::OP_SUSP && cmd == fesl_pkg::CMD_CONFIRM
        |=> !status_o[fesl_pkg::SR_READY] && !status_o[fesl_pkg::SR_PSUSP])
        else $error("program resume wrong");
    erase_susp_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && seq_q == fesl_pkg::SQ_NONE && eop_q == fesl_pkg::OP_RUN && cmd == fesl_pkg::CMD_SUSPEND
        && ecnt_q != 20'h0_0001 && !vpp_lockout_i
        |=> status_o[fesl_pkg::SR_READY] && status_o[fesl_pkg::SR_ESUSP] && $stable(ecnt_q))
        else $error("erase suspend wrong");
    resume_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pop_q != fesl_pkg::OP_NONE && eop_q == fesl_pkg::OP_SUSP |=> eop_q != fesl_pkg::OP_RUN)
        else $error("erase resumed over program");
    erase_resume_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && seq_q == fesl_pkg::SQ_NONE && pop_q == fesl_pkg::OP_NONE && eop_q == fesl_pkg::OP_SUSP
        && cmd == fesl_pkg::CMD_CONFIRM |=> eop_q == fesl_pkg::OP_RUN && !status_o[fesl_pkg::SR_ESUSP])
        else $error("erase resume wrong");
    standby_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_n_i && eop_q == fesl_pkg::OP_RUN |=> !standby_o)
        else $error("standby during erase");
    lock_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && seq_q == fesl_pkg::SQ_LOCK && cmd != fesl_pkg::CMD_LOCK && cmd != fesl_pkg::CMD_CONFIRM
        && cmd != fesl_pkg::CMD_LOCK_DOWN && cmd != fesl_pkg::CMD_SET_RCR
        |=> err_q[fesl_pkg::SR_ERASE] && err_q[fesl_pkg::SR_PROG])
        else $error("lock sequence error missing");
    lockdown_wp_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && seq_q == fesl_pkg::SQ_LOCK && cmd == fesl_pkg::CMD_CONFIRM && ldn_q[blk] && !wp_n_i
        |=> lock_q[$past(blk)])
        else $error("locked-down block unlocked under write protect");
endmodule

// file: fesl_pkg.sv
package fesl_pkg;
    localparam int unsigned ADDR_W = 11;
    localparam int unsigned BLK_W  = 3;
    localparam int unsigned NBLK   = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W  = 20;

    // Timing at 10 MHz
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned ERASE_TIME_US = 10000;
    localparam int unsigned PROG_TIME_US  = 100;
    localparam logic [CNT_W-1:0] ERASE_CYC = CNT_W'(ERASE_TIME_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] PROG_CYC  = CNT_W'(PROG_TIME_US * 1000 / CLK_PERIOD_NS);

    // Command codes on the low data byte
    localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_ID     = 8'h90;
    localparam logic [7:0] CMD_QUERY       = 8'h98;
    localparam logic [7:0] CMD_CLEAR       = 8'h50;
    localparam logic [7:0] CMD_PROG        = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT    = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
    localparam logic [7:0] CMD_LOCK_SETUP  = 8'h60;
    localparam logic [7:0] CMD_LOCK        = 8'h01;
    localparam logic [7:0] CMD_LOCK_DOWN   = 8'h2F;
    localparam logic [7:0] CMD_SET_RCR     = 8'h03;

    // Status register bit positions
    localparam int unsigned SR_READY   = 7;
    localparam int unsigned SR_ESUSP   = 6;
    localparam int unsigned SR_ERASE   = 5;
    localparam int unsigned SR_PROG    = 4;
    localparam int unsigned SR_VPP     = 3;
    localparam int unsigned SR_PSUSP   = 2;
    localparam int unsigned SR_LOCK    = 1;
    localparam int unsigned SR_BLK_ERS = 0;

    // Reset values
    localparam logic [NBLK-1:0]   LOCK_RST = 8'hFF;
    localparam logic [NBLK-1:0]   LDN_RST  = 8'h00;
    localparam logic [DATA_W-1:0] RCR_RST  = 16'hBFCF;
    localparam logic [7:0]        ERR_RST  = 8'h00;

    typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_ID, RM_QUERY} fesl_rmode_t;
    typedef enum logic [1:0] {SQ_NONE, SQ_PROG, SQ_ERASE, SQ_LOCK} fesl_seq_t;
    typedef enum logic [1:0] {OP_NONE, OP_RUN, OP_SUSP} fesl_op_t;
endpackage

// file: fesl_array_model.sv
`timescale 1ns/10ps
// Behavioural array behind the controller: erase fills a block with ones
module fesl_array_model (
    input  wire logic        clk_i,
    input  wire logic        erase_i,
    input  wire logic        prog_i,
    input  wire logic [10:0] addr_i,
    input  wire logic [15:0] data_i,
    output logic      [15:0] rdata_o
);
    logic [15:0] mem [0:2047];
    // Program can only clear bits, so AND keeps a double program honest
    always @(posedge clk_i) begin
        if (erase_i) begin
            for (int i = 0; i < 256; i++) begin
                mem[{addr_i[10:8], 8'h00} + 11'(i)] <= 16'hFFFF;
            end
        end
        if (prog_i) begin
            mem[addr_i] <= mem[addr_i] & data_i;
        end
    end
    assign rdata_o = mem[addr_i];
endmodule

// file: flash_erase_suspend_lock_ctrl_tb.sv
`timescale 1ns/10ps
module flash_erase_suspend_lock_ctrl_tb;
    logic clk_i = 0, rst_i = 1, ce_n_i = 0, we_i = 0, wp_n_i = 1, vpp_i = 0, fail_i = 0;
    logic [10:0] addr_i = 0;
    logic [15:0] wdata_i = 0, ardata, rdata_o, rcr_o, aaddr16, adata;
    logic [10:0] aaddr;
    logic [7:0]  status_o;
    logic        standby_o, aerase, aprog;
    int          err_count = 0, samples_checked = 0;
    logic [10:0] exp_q [$];
    // 10 MHz clock
    always #50 clk_i = ~clk_i;
    fesl_ctrl #(.ERASE_CYCLES(20'h0_0014)) i_fesl_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_n_i(ce_n_i),
        .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .wp_n_i(wp_n_i), .vpp_lockout_i(vpp_i),
        .erase_fail_i(fail_i), .array_rdata_i(ardata), .rdata_o(rdata_o), .status_o(status_o),
        .standby_o(standby_o), .array_erase_o(aerase), .array_prog_o(aprog), .array_addr_o(aaddr),
        .array_data_o(adata), .rcr_o(rcr_o));
    fesl_array_model i_fesl_array_model (.clk_i(clk_i), .erase_i(aerase), .prog_i(aprog),
        .addr_i(aaddr), .data_i(adata), .rdata_o(ardata));
    assign aaddr16 = {5'h00, aaddr};
    task automatic chk(input logic [15:0] e, input logic [15:0] g, input logic [15:0] m);
        samples_checked++;
        if ((g & m) !== (e & m)) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, g & m, e & m);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d, checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One bus write: strobe held for one cycle, dropped at the next falling edge without waiting further
    task automatic wr(input logic [15:0] d, input logic [10:0] a);
        @(negedge clk_i);
        we_i = 1;
        addr_i = a;
        wdata_i = d;
        @(negedge clk_i);
        we_i = 0;
    endtask
    task automatic st(input logic [7:0] e, input logic [7:0] m);
        @(negedge clk_i);
        chk({8'h00, e}, {8'h00, status_o}, {8'h00, m});
    endtask
    // Identifier read of a block: lock bit on bit 0, lock-down on bit 1
    task automatic idr(input logic [10:0] a, input logic [1:0] e);
        wr(16'h0090, a);
        repeat (3) @(negedge clk_i);
        chk({14'h0000, e}, rdata_o, 16'h0003);
    endtask
    task automatic wait_ready;
        int n;
        for (n = 0; n < 2000 && status_o[7] !== 1'b1; n++) @(negedge clk_i);
        if (n == 2000) begin
            err_count++;
            $display("Error %0t: ready never came back", $time);
            end_of_test();
        end
    endtask
    // Scoreboard: each erase pulse must hit the oldest noted block base
    always @(negedge clk_i) begin
        if (aerase === 1'b1) begin
            if (exp_q.size() == 0) chk(16'hFFFF, aaddr16, 16'hFFFF);
            else chk({5'h00, exp_q.pop_front()}, aaddr16, 16'hFFFF);
        end
    end
    initial begin
        void'($urandom(65));
        repeat (2) @(negedge clk_i);
        rst_i = 0;
        st(8'h80, 8'hFF);
        chk(16'hBFCF, rcr_o, 16'hFFFF);
        idr(11'h100, 2'b01);
        wr(16'h0020, 11'h100);
        wr(16'h00D0, 11'h100);
        st(8'h82, 8'hFF);
        wr(16'h0050, 11'h000);
        vpp_i = 1;
        wr(16'h0060, 11'h100);
        wr(16'h00D0, 11'h100);
        idr(11'h100, 2'b00);
        wr(16'h0020, 11'h100);
        wr(16'h00D0, 11'h100);
        st(8'h08, 8'h08);
        wr(16'h0050, 11'h000);
        wr(16'h0040, 11'h105);
        wr(16'h1234, 11'h105);
        st(8'h08, 8'h08);
        vpp_i = 0;
        wr(16'h0050, 11'h000);
        fail_i = 1'($urandom % 2);
        exp_q.push_back(11'h100);
        wr(16'h0020, 11'h100);
        wr(16'h00D0, 11'h100);
        st(8'h01, 8'h81);
        wr(16'h00B0, 11'h7FF);
        st(8'hC0, 8'hC0);
        wr(16'h0060, 11'h200);
        wr(16'h00FF, 11'h200);
        st(8'h30, 8'h30);
        wr(16'h0050, 11'h000);
        st(8'h00, 8'h30);
        wr(16'h00D0, 11'h000);
        st(8'h00, 8'hC0);
        ce_n_i = 1;
        wait_ready();
        st({2'b10, fail_i, 5'h00}, 8'hE0);
        chk(16'h0001, {15'h0000, standby_o}, 16'h0001);
        ce_n_i = 0;
        wr(16'h00FF, 11'h1C3);
        repeat (2) @(negedge clk_i);
        chk(16'hFFFF, rdata_o, 16'hFFFF);
        wr(16'h0040, 11'h1C3);
        wr(16'h1234, 11'h1C3);
        st(8'h00, 8'h80);
        wr(16'h00B0, 11'h000);
        st(8'h84, 8'h84);
        wr(16'h00D0, 11'h000);
        st(8'h00, 8'h84);
        wait_ready();
        wr(16'h00FF, 11'h1C3);
        repeat (2) @(negedge clk_i);
        chk(16'h1234, rdata_o, 16'hFFFF);
        wr(16'h0060, 11'h200);
        wr(16'h002F, 11'h200);
        wp_n_i = 0;
        wr(16'h0060, 11'h200);
        wr(16'h00D0, 11'h200);
        idr(11'h200, 2'b11);
        @(negedge clk_i);
        rst_i = 1;
        @(negedge clk_i);
        rst_i = 0;
        wp_n_i = 1;
        idr(11'h200, 2'b01);
        wr(16'h0060, 11'h0A5);
        wr(16'h0003, 11'h0A5);
        st(8'h80, 8'hFF);
        chk(16'h00A5, rcr_o, 16'hFFFF);
        chk(16'h0000, {5'h00, 11'(exp_q.size())}, 16'hFFFF);
        end_of_test();
    end
endmodule
